/* File: core/fsb_params.svh */
// constants for the second flash status byte block
`ifndef FSB_PARAMS_SVH
`define FSB_PARAMS_SVH

// serial opcodes
`define FSB_OP_READ_BYTE2 8'h35
`define FSB_OP_WRITE_STATUS 8'h01

// field positions within the second status byte
`define FSB_BIT_UNUSED_HI 7
`define FSB_BIT_PROTECT_INVERT 6
`define FSB_BIT_PAGE_THREE_LOCK 5
`define FSB_BIT_PAGE_TWO_LOCK 4
`define FSB_BIT_PAGE_ONE_LOCK 3
`define FSB_BIT_UNUSED_LO 2
`define FSB_BIT_FOUR_LINE_ENABLE 1
`define FSB_BIT_STATUS_GUARD_HI 0

// field position of the lower guard bit within the first data byte
`define FSB_BIT_STATUS_GUARD_LO 7

// masks and reset values
`define FSB_BYTE2_RESET 8'h00
`define FSB_BYTE2_WRITE_MASK 8'h7B
`define FSB_BYTE2_LOCK_MASK 8'h38
`define FSB_GUARD_LO_RESET 1'b0

// security page numbers as carried on the page select input
`define FSB_PAGE_ONE 2'h1
`define FSB_PAGE_TWO 2'h2
`define FSB_PAGE_THREE 2'h3

// frame bookkeeping
`define FSB_BIT_LAST 3'h7
`define FSB_DATA_BYTES_ONE 2'h1
`define FSB_DATA_BYTES_TWO 2'h2
`define FSB_DATA_BYTES_OVER 2'h3

`endif

/* File: core/fsb_pkg.sv */
// types shared by the second flash status byte block
`default_nettype none

package fsb_pkg;

  // phase of the serial frame
  typedef enum logic [1:0] {
    ls_opcode,
    ls_read,
    ls_write,
    ls_ignore
  } fsb_link_e;

  // protection of the status bits
  typedef enum logic [1:0] {
    pm_soft,
    pm_hard,
    pm_lockdown,
    pm_permanent
  } fsb_prot_e;

endpackage

`default_nettype wire

/* File: core/fsb_sync.sv */
// two flip-flop synchroniser for levels and quasi-static words
`default_nettype none

module fsb_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // destination clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [WIDTH-1:0] rst_val, // constant value taken under reset
  input wire logic [WIDTH-1:0] din, // level from the other domain
  output logic [WIDTH-1:0] dout // synchronised level
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] dout_d;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_comb begin
        meta_d[i] = rst ? rst_val[i] : din[i];
        dout_d[i] = rst ? rst_val[i] : meta_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    dout <= dout_d;
  end

endmodule

`default_nettype wire

/* File: core/fsb_status_byte.sv */
// second status byte of a serial flash: serial access, protection and page locks
`include "fsb_params.svh"
`default_nettype none

// Notes on behaviour
// - bits 7 and 2 of the byte are reserved, read only and always read as 0.
// - bit 6 inverts the protected array region, reads and writes, and resets to 0.
// - bit 5 locks the third security page, resets to 0, and when set refuses erase and program there.
// - bit 4 locks the second security page, resets to 0, and when set erase and program there do nothing.
// - bit 3 locks the first security page, resets to 0, and when set erase and program there do nothing.
// - bit 1 is the four line enable, resets to 0, and while 0 the pause and protect pins are plain inputs.
// - while the four line enable is 1 the pause and protect pins are sampled as data lines but never driven.
// - bit 0 is the upper status guard, read and written, and with the lower guard it gates status writes.
// - a status write can change only bits 6 to 3, 1 and 0, never the reserved bits.
// - after opcode 35h the byte is shifted out msb first and repeated with fresh values while clocked.
// - the status write may carry a second data byte laid out exactly as the status byte.
// - the two guard bits and the protect pin choose soft, hard, lock-down or permanent protection.
// - a page lock bit once set returns to 0 only under reset.
module fsb_status_byte (
  input wire logic ref_clk, // system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic wel_in, // write enable latch from the first status byte
  input wire logic sec_req, // one-cycle request to erase or program a security page
  input wire logic [1:0] sec_page, // security page number, 1 to 3
  input wire logic sclk, // serial clock from the host
  input wire logic cs_n, // chip select, active low
  input wire logic si, // serial data in
  input wire logic hold_n_in, // pause pin level, also io3
  input wire logic wp_n_in, // protect pin level, also io2
  output logic so_out, // serial data out
  output logic so_oe, // serial data out enable
  output logic io2_oe, // protect pin output enable
  output logic io3_oe, // pause pin output enable
  output logic io2_out, // protect pin output level
  output logic io3_out, // pause pin output level
  output logic quad_io2_q, // protect pin sampled as data line
  output logic quad_io3_q, // pause pin sampled as data line
  output logic wel_clear, // one-cycle pulse clearing the write enable latch
  output logic sec_grant, // one-cycle pulse, page operation allowed
  output logic sec_deny, // one-cycle pulse, page operation refused
  output logic protect_invert, // complement of the protected region
  output logic page_one_lock, // first security page locked
  output logic page_two_lock, // second security page locked
  output logic page_three_lock, // third security page locked
  output logic four_line_enable, // pins serve as data lines
  output logic status_guard_hi, // upper status guard
  output logic status_guard_lo, // lower status guard
  output logic [1:0] prot_mode // current status protection mode
);

  function automatic fsb_pkg::fsb_prot_e guard_mode(input logic hi, input logic lo,
                                                    input logic wp_high);
    fsb_pkg::fsb_prot_e m;
    m = fsb_pkg::pm_soft;
    case ({hi, lo})
      2'h0: m = fsb_pkg::pm_soft;
      2'h1: m = wp_high ? fsb_pkg::pm_soft : fsb_pkg::pm_hard;
      2'h2: m = fsb_pkg::pm_lockdown;
      2'h3: m = fsb_pkg::pm_permanent;
      default: m = fsb_pkg::pm_soft;
    endcase
    return m;
  endfunction

  // ---------------- link domain; link and serial out registers reset by the frame's own chip select
  fsb_pkg::fsb_link_e link_q, link_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] byte_sclk;
  logic [7:0] rx_full;
  logic pause;

  // frame summary kept across the chip select edge for the system domain
  logic frame_wr_q, frame_wr_d;
  logic frame_align_q, frame_align_d;
  logic [1:0] frame_cnt_q, frame_cnt_d;
  logic [7:0] frame_b1_q, frame_b1_d;
  logic [7:0] frame_b2_q, frame_b2_d;
  logic quad_io2_d, quad_io3_d;

  logic [7:0] byte_q;
  logic so_d, so_oe_d;

  // the byte changes only between frames, so a plain word synchroniser is safe;
  // it lags by two serial edges, long before the first reload after the opcode
  fsb_sync #(.WIDTH(8)) u_byte_sync (
    .clk(sclk),
    .rst(1'b0),
    .rst_val(`FSB_BYTE2_RESET),
    .din(byte_q),
    .dout(byte_sclk)
  );

  assign rx_full = {rx_q[6:0], si};
  // pause only acts while the pin keeps its control role
  assign pause = !hold_n_in && !byte_sclk[`FSB_BIT_FOUR_LINE_ENABLE];

  always_comb begin
    link_d = link_q;
    bit_d = bit_q;
    rx_d = rx_q;
    tx_d = tx_q;
    if (!pause) begin
      bit_d = bit_q + 3'h1;
      rx_d = rx_full;
      tx_d = {tx_q[6:0], 1'b0};
      case (link_q)
        fsb_pkg::ls_opcode: begin
          if (bit_q == `FSB_BIT_LAST) begin
            if (rx_full == `FSB_OP_READ_BYTE2) begin
              link_d = fsb_pkg::ls_read;
              tx_d = byte_sclk;
            end else if (rx_full == `FSB_OP_WRITE_STATUS) begin
              link_d = fsb_pkg::ls_write;
            end else begin
              link_d = fsb_pkg::ls_ignore;
            end
          end
        end
        fsb_pkg::ls_read: begin
          if (bit_q == `FSB_BIT_LAST) begin
            tx_d = byte_sclk;
          end
        end
        fsb_pkg::ls_write: begin
        end
        fsb_pkg::ls_ignore: begin
        end
        default: link_d = fsb_pkg::ls_ignore;
      endcase
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      link_q <= fsb_pkg::ls_opcode;
      bit_q <= 3'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
    end else begin
      link_q <= link_d;
      bit_q <= bit_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
    end
  end

  // summary registers carry no reset: they are rewritten on every edge of a
  // frame and read by the system domain only after that frame has ended
  always_comb begin
    frame_wr_d = (link_d == fsb_pkg::ls_write);
    frame_align_d = (bit_d == 3'h0);
    frame_cnt_d = frame_cnt_q;
    frame_b1_d = frame_b1_q;
    frame_b2_d = frame_b2_q;
    quad_io2_d = byte_sclk[`FSB_BIT_FOUR_LINE_ENABLE] ? wp_n_in : quad_io2_q;
    quad_io3_d = byte_sclk[`FSB_BIT_FOUR_LINE_ENABLE] ? hold_n_in : quad_io3_q;
    if (link_q == fsb_pkg::ls_opcode) begin
      frame_cnt_d = 2'h0;
    end
    if (!pause && link_q == fsb_pkg::ls_write && bit_q == `FSB_BIT_LAST) begin
      case (frame_cnt_q)
        2'h0: frame_b1_d = rx_full;
        2'h1: frame_b2_d = rx_full;
        default: frame_b2_d = frame_b2_q;
      endcase
      if (frame_cnt_q != `FSB_DATA_BYTES_OVER) begin
        frame_cnt_d = frame_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge sclk) begin
    frame_wr_q <= frame_wr_d;
    frame_align_q <= frame_align_d;
    frame_cnt_q <= frame_cnt_d;
    frame_b1_q <= frame_b1_d;
    frame_b2_q <= frame_b2_d;
    quad_io2_q <= quad_io2_d;
    quad_io3_q <= quad_io3_d;
  end

  // data leaves on the falling edge so the host samples it on the next rise
  always_comb begin
    so_oe_d = (link_q == fsb_pkg::ls_read) && !pause;
    so_d = tx_q[7];
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so_out <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so_out <= so_d;
      so_oe <= so_oe_d;
    end
  end

  // ---------------- system domain
  logic cs_sync, wp_sync;
  logic cs_prev_q, cs_prev_d;
  logic [7:0] byte_d;
  logic guard_lo_q, guard_lo_d;
  logic wel_clear_d, sec_grant_d, sec_deny_d;
  logic frame_end;
  logic wp_high;
  logic commit;
  logic page_locked;
  fsb_pkg::fsb_prot_e mode_now;

  fsb_sync #(.WIDTH(2)) u_pin_sync (
    .clk(ref_clk),
    .rst(reset),
    .rst_val(2'h3),
    .din({cs_n, wp_n_in}),
    .dout({cs_sync, wp_sync})
  );

  assign frame_end = cs_sync && !cs_prev_q;
  // in four line mode the protect pin is a data line and no longer guards
  assign wp_high = wp_sync || byte_q[`FSB_BIT_FOUR_LINE_ENABLE];
  assign mode_now = guard_mode(byte_q[`FSB_BIT_STATUS_GUARD_HI], guard_lo_q, wp_high);
  assign commit = frame_end && frame_wr_q && frame_align_q && wel_in
                  && (frame_cnt_q == `FSB_DATA_BYTES_ONE || frame_cnt_q == `FSB_DATA_BYTES_TWO)
                  && (mode_now == fsb_pkg::pm_soft);

  always_comb begin
    case (sec_page)
      `FSB_PAGE_ONE: page_locked = byte_q[`FSB_BIT_PAGE_ONE_LOCK];
      `FSB_PAGE_TWO: page_locked = byte_q[`FSB_BIT_PAGE_TWO_LOCK];
      `FSB_PAGE_THREE: page_locked = byte_q[`FSB_BIT_PAGE_THREE_LOCK];
      default: page_locked = 1'b1;
    endcase
  end

  always_comb begin
    cs_prev_d = cs_sync;
    byte_d = byte_q;
    guard_lo_d = guard_lo_q;
    wel_clear_d = frame_end && frame_wr_q;
    sec_grant_d = sec_req && !page_locked;
    sec_deny_d = sec_req && page_locked;
    if (commit) begin
      guard_lo_d = frame_b1_q[`FSB_BIT_STATUS_GUARD_LO];
      if (frame_cnt_q == `FSB_DATA_BYTES_TWO) begin
        // writable bits only, reserved stay 0, set locks are sticky
        byte_d = (frame_b2_q & `FSB_BYTE2_WRITE_MASK)
                 | (byte_q & `FSB_BYTE2_LOCK_MASK);
      end
    end
    if (reset) begin
      cs_prev_d = 1'b1;
      byte_d = `FSB_BYTE2_RESET;
      guard_lo_d = `FSB_GUARD_LO_RESET;
      wel_clear_d = 1'b0;
      sec_grant_d = 1'b0;
      sec_deny_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    cs_prev_q <= cs_prev_d;
    byte_q <= byte_d;
    guard_lo_q <= guard_lo_d;
    wel_clear <= wel_clear_d;
    sec_grant <= sec_grant_d;
    sec_deny <= sec_deny_d;
    protect_invert <= byte_d[`FSB_BIT_PROTECT_INVERT];
    page_one_lock <= byte_d[`FSB_BIT_PAGE_ONE_LOCK];
    page_two_lock <= byte_d[`FSB_BIT_PAGE_TWO_LOCK];
    page_three_lock <= byte_d[`FSB_BIT_PAGE_THREE_LOCK];
    four_line_enable <= byte_d[`FSB_BIT_FOUR_LINE_ENABLE];
    status_guard_hi <= byte_d[`FSB_BIT_STATUS_GUARD_HI];
    status_guard_lo <= guard_lo_d;
    prot_mode <= reset ? 2'h0 : mode_now;
  end

  // no quad transfer is issued here, so the data lines are never driven
  always_ff @(posedge ref_clk) begin
    io2_oe <= 1'b0;
    io3_oe <= 1'b0;
    io2_out <= 1'b0;
    io3_out <= 1'b0;
  end

endmodule

`default_nettype wire

/* File: sim/fsb_status_byte_checker.sv */
// port assertions for the second status byte block
`default_nettype none

module fsb_status_byte_checker (
  input wire logic ref_clk, // clock
  input wire logic reset, // reset
  input wire logic sec_req, // page request
  input wire logic [1:0] sec_page, // page number
  input wire logic cs_n, // select
  input wire logic so_out, // serial out
  input wire logic so_oe, // serial out enable
  input wire logic io2_oe, // pin enable
  input wire logic io3_oe, // pin enable
  input wire logic wel_clear, // latch clear
  input wire logic sec_grant, // grant
  input wire logic sec_deny, // deny
  input wire logic protect_invert, // invert
  input wire logic page_one_lock, // lock
  input wire logic page_two_lock, // lock
  input wire logic page_three_lock, // lock
  input wire logic four_line_enable, // quad mode
  input wire logic status_guard_hi, // guard
  input wire logic status_guard_lo, // guard
  input wire logic [1:0] prot_mode // mode
);
  logic [3:0] lk;
  logic deny_q;
  // page 0 has no lock and is always refused
  assign lk = {page_three_lock, page_two_lock, page_one_lock, 1'b1};
  always_ff @(posedge ref_clk) begin
    deny_q <= lk[sec_page];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_sec_ans;
    sec_req |=> sec_deny == deny_q && sec_grant != sec_deny;
  endproperty
  a_sec_ans: assert property (p_sec_ans) else $error("page answer wrong");
  property p_lock_hold;
    !($fell(page_one_lock) || $fell(page_two_lock) || $fell(page_three_lock));
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock cleared");
  property p_so_idle;
    cs_n && $past(cs_n) |-> !so_oe && !so_out;
  endproperty
  a_so_idle: assert property (p_so_idle) else $error("serial out while idle");
  property p_no_drive;
    !four_line_enable |-> !io2_oe && !io3_oe;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("pins driven");
  property p_wel_pulse;
    wel_clear |=> !wel_clear;
  endproperty
  a_wel_pulse: assert property (p_wel_pulse) else $error("latch clear too long");
  property p_byte_commit;
    $changed(protect_invert) || $changed(four_line_enable) |-> wel_clear;
  endproperty
  a_byte_commit: assert property (p_byte_commit) else $error("byte changed off write");
  property p_guard_commit;
    $changed(status_guard_hi) || $rose(page_one_lock) |-> wel_clear;
  endproperty
  a_guard_commit: assert property (p_guard_commit) else $error("guard changed off write");
  property p_perm;
    status_guard_hi && status_guard_lo |-> ##[0:2] prot_mode == 2'h3;
  endproperty
  a_perm: assert property (p_perm) else $error("not permanent");
endmodule

bind fsb_status_byte fsb_status_byte_checker chk (.ref_clk, .reset, .sec_req, .sec_page,
  .cs_n, .so_out, .so_oe, .io2_oe, .io3_oe, .wel_clear, .sec_grant, .sec_deny,
  .protect_invert, .page_one_lock, .page_two_lock, .page_three_lock, .four_line_enable,
  .status_guard_hi, .status_guard_lo, .prot_mode);

`default_nettype wire

/* File: sim/fsb_host.sv */
// serial host model issuing status frames in mode 0
`default_nettype none

module fsb_host (
  output logic sclk, // serial clock
  output logic cs_n, // chip select
  output logic si, // data to device
  input wire logic so_out // data from device
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // clock stands low outside frames; si is flipped once released
  task automatic xfer(input logic [31:0] d, input int n, output logic [31:0] r);
    r = '0;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = d[31-i];
      #7.5 sclk = 1'b1;
      r = {r[30:0], so_out};
      #7.5 sclk = 1'b0;
    end
    #10 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

`default_nettype wire

/* File: sim/flash_status_byte_two_tb.sv */
// self-checking bench for the second status byte
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module flash_status_byte_two_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, reset = 1'b1, wel_in = 1'b0, sec_req = 1'b0;
  logic [1:0] sec_page = 2'h0;
  logic wp_n = 1'b1;
  int wel_seen = 0;
  logic sclk, cs_n, si, so_out, so_oe, io2_oe, io3_oe, wel_clear, sec_grant, sec_deny;
  logic protect_invert, page_one_lock, page_two_lock, page_three_lock;
  logic four_line_enable, status_guard_hi, status_guard_lo;
  logic [1:0] prot_mode;
  logic [31:0] r;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 ref_clk = ~ref_clk;
  fsb_status_byte uut (.ref_clk, .reset, .wel_in, .sec_req, .sec_page, .sclk, .cs_n, .si,
    .hold_n_in(1'b1), .wp_n_in(wp_n), .so_out, .so_oe, .io2_oe, .io3_oe, .io2_out(),
    .io3_out(), .quad_io2_q(), .quad_io3_q(), .wel_clear, .sec_grant, .sec_deny,
    .protect_invert, .page_one_lock, .page_two_lock, .page_three_lock, .four_line_enable,
    .status_guard_hi, .status_guard_lo, .prot_mode);
  fsb_host host (.sclk, .cs_n, .si, .so_out);

  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // every write frame with a full opcode clears the latch, refused or not
  always @(posedge ref_clk) begin
    if (wel_clear === 1'b1) begin
      wel_seen++;
    end
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test;
    end
  end
  // settle long enough for the byte to cross back before the next read
  task automatic wr(input logic [7:0] b1, input logic [7:0] b2, input int n);
    int w;
    w = wel_seen;
    host.xfer({8'h01, b1, b2, 8'h00}, n, r);
    repeat (8) @(posedge ref_clk);
    `CHK("wel_clear", w + 1, wel_seen)
  endtask
  task automatic rd(input logic [7:0] e);
    host.xfer({8'h35, 24'h0}, 24, r);
    `CHK("byte", e, r[15:8])
    `CHK("repeat", e, r[7:0])
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic sec(input logic [1:0] p, input logic deny);
    @(posedge ref_clk);
    sec_req <= 1'b1;
    sec_page <= p;
    @(posedge ref_clk);
    sec_req <= 1'b0;
    #1;
    `CHK("deny", deny, sec_deny)
    `CHK("grant", ~deny, sec_grant)
  endtask
  task automatic t_defaults;
    rd(8'h00);
    `CHK("pins", 2'h0, {io2_oe, io3_oe})
    `CHK("mode", 2'h0, prot_mode)
  endtask
  task automatic t_no_latch;
    wr(8'h00, 8'h40, 24);
    rd(8'h00);
  endtask
  task automatic t_invert;
    @(posedge ref_clk);
    wel_in <= 1'b1;
    wr(8'h00, 8'h44, 24);
    rd(8'h40);
    `CHK("invert", 1'b1, protect_invert)
  endtask
  task automatic t_one_byte;
    wr(8'h80, 8'h00, 16);
    rd(8'h40);
    `CHK("guard_lo", 1'b1, status_guard_lo)
    @(posedge ref_clk);
    wp_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    `CHK("hard", 2'h1, prot_mode)
    wr(8'h00, 8'h00, 24);
    `CHK("hard_guard", 1'b1, status_guard_lo)
    @(posedge ref_clk);
    wp_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    `CHK("soft", 2'h0, prot_mode)
  endtask
  task automatic t_locks;
    sec(2'h1, 1'b0);
    sec(2'h2, 1'b0);
    sec(2'h3, 1'b0);
    sec(2'h0, 1'b1);
    wr(8'h00, 8'h3A, 24);
    rd(8'h3A);
    `CHK("quad", 1'b1, four_line_enable)
    sec(2'h1, 1'b1);
    sec(2'h2, 1'b1);
    sec(2'h3, 1'b1);
  endtask
  task automatic t_guard;
    wr(8'h80, 8'h01, 24);
    rd(8'h39);
    `CHK("locks", 3'h7, {page_three_lock, page_two_lock, page_one_lock})
    `CHK("guard", 2'h3, {status_guard_hi, status_guard_lo})
    `CHK("mode", 2'h3, prot_mode)
    wr(8'h00, 8'h40, 24);
    rd(8'h39);
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_defaults;
    t_no_latch;
    t_invert;
    t_one_byte;
    t_locks;
    t_guard;
    stop_test;
  end
endmodule

`default_nettype wire
